// ### fsp_pkg.sv
// Purpose: Shared constants and types for the sector guard command host.
// Assumes: 20 MHz clock; the flash sits on an asynchronous parallel bus.
// Notes: Addresses are the command-table addresses as driven on the pins.
package fsp_pkg;

  localparam int CLK_MHZ = 20;
  localparam int T_SETUP_NS = 50;
  localparam int T_PULSE_NS = 100;
  localparam int T_HOLD_NS = 50;
  localparam int T_RECOV_NS = 50;
  localparam int T_ACC_NS = 100;
  localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_CYC = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOV_CYC = (T_RECOV_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  // Extra read cycles cover the three-stage data synchroniser
  localparam int SYNC_CYC = 3;

  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] ENT_LOCK = 8'h40;
  localparam logic [7:0] ENT_PERSIST = 8'hc0;
  localparam logic [7:0] ENT_FREEZE = 8'h50;
  localparam logic [7:0] ENT_DYNAMIC = 8'he0;
  localparam logic [7:0] CMD_PROG = 8'ha0;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_ERASE_GO = 8'h30;
  localparam logic [7:0] CMD_EXIT1 = 8'h90;
  localparam logic [7:0] CMD_EXIT2 = 8'h00;
  localparam logic [7:0] GUARD_SET = 8'h00;
  localparam logic [7:0] GUARD_CLR = 8'h01;
  localparam logic [7:0] STAT_GUARDED = 8'h00;

  localparam logic [11:0] ADR_W_U1 = 12'h555;
  localparam logic [11:0] ADR_W_U2 = 12'h2aa;
  localparam logic [11:0] ADR_B_U1 = 12'haaa;
  localparam logic [11:0] ADR_B_U2_SHORT = 12'h055;
  localparam logic [11:0] ADR_B_U2_LONG = 12'h555;
  localparam logic [11:0] ADR_ZERO = 12'h000;

  localparam int SECTOR_LSB = 16;
  localparam int LOCK_SECURED_BIT = 0;
  localparam int LOCK_PERSIST_BIT = 1;
  localparam int LOCK_SECRET_KEY_BIT = 2;
  localparam int BUF_WC_MAX = 31;
  localparam int STEP_W = 3;

  typedef enum logic [3:0] {
    OP_LOCK_PROG, OP_LOCK_READ, OP_PERSIST_PROG, OP_PERSIST_ERASE,
    OP_PERSIST_READ, OP_FREEZE_SET, OP_FREEZE_READ, OP_DYNAMIC_SET,
    OP_DYNAMIC_CLR, OP_DYNAMIC_READ
  } op_type;

endpackage : fsp_pkg

// ### cycle_if.sv
// Purpose: Carries one bus-cycle request between sequencer and engine.
// Assumes: req and done are one-cycle pulses on the shared clock.
// Notes: One request outstanding at a time.
`timescale 1ns/10ps
`default_nettype none
interface cycle_if #(parameter int ADDR_W = 24);
  logic req;
  logic is_read;
  logic [ADDR_W-1:0] addr;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport issuer (output req, is_read, addr, wdata, input done, rdata);
  modport engine (input req, is_read, addr, wdata, output done, rdata);
endinterface : cycle_if
`default_nettype wire

// ### bus_cycle_engine.sv
// Purpose: Runs one asynchronous write or read cycle on the flash pins.
// Assumes: Flash data arrive asynchronously and are synchronised here.
// Notes: Chip select brackets the strobes on both sides.
`timescale 1ns/10ps
`default_nettype none
module bus_cycle_engine #(
  parameter int ADDR_W = 24
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  cycle_if.engine cyc,
  output logic [ADDR_W-1:0] addr_o,
  output logic [15:0] dq_o,
  output logic dq_oe_o,
  input wire logic [15:0] dq_i,
  output logic ce_n_o,
  output logic we_n_o,
  output logic oe_n_o
);

  typedef enum {C_IDLE, C_SETUP, C_PULSE, C_HOLD, C_RECOV} cyc_state_type;
  cyc_state_type state_ff;
  logic [3:0] cnt_ff;
  logic rd_ff;
  logic done_ff;
  logic [15:0] rdata_ff;
  logic [15:0] dq_s1_ff, dq_s2_ff, dq_s3_ff;

  assign cyc.done = done_ff;
  assign cyc.rdata = rdata_ff;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dq_s1_ff <= 16'h0000;
      dq_s2_ff <= 16'h0000;
      dq_s3_ff <= 16'h0000;
    end else begin
      dq_s1_ff <= dq_i;
      dq_s2_ff <= dq_s1_ff;
      dq_s3_ff <= dq_s2_ff;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= C_IDLE;
      cnt_ff <= 4'h0;
      rd_ff <= 1'b0;
      done_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      addr_o <= '0;
      dq_o <= 16'h0000;
      dq_oe_o <= 1'b0;
      ce_n_o <= 1'b1;
      we_n_o <= 1'b1;
      oe_n_o <= 1'b1;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        C_IDLE: begin
          if (cyc.req) begin
            rd_ff <= cyc.is_read;
            addr_o <= cyc.addr;
            dq_o <= cyc.wdata;
            dq_oe_o <= !cyc.is_read;
            ce_n_o <= 1'b0;
            cnt_ff <= 4'(fsp_pkg::SETUP_CYC - 1);
            state_ff <= C_SETUP;
          end
        end
        C_SETUP: begin
          if (cnt_ff == 4'h0) begin
            // Strobe falls after select, so the address latches here
            we_n_o <= rd_ff;
            oe_n_o <= !rd_ff;
            cnt_ff <= rd_ff ?
              4'(fsp_pkg::ACC_CYC + fsp_pkg::SYNC_CYC - 1) :
              4'(fsp_pkg::PULSE_CYC - 1);
            state_ff <= C_PULSE;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        C_PULSE: begin
          if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
          end else if (!rd_ff || dq_s2_ff == dq_s3_ff) begin
            // Strobe rises before select, so the data latch here
            we_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            if (rd_ff) begin
              rdata_ff <= dq_s3_ff;
            end
            cnt_ff <= 4'(fsp_pkg::HOLD_CYC - 1);
            state_ff <= C_HOLD;
          end
        end
        C_HOLD: begin
          if (cnt_ff == 4'h0) begin
            ce_n_o <= 1'b1;
            dq_oe_o <= 1'b0;
            cnt_ff <= 4'(fsp_pkg::RECOV_CYC - 1);
            state_ff <= C_RECOV;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        C_RECOV: begin
          if (cnt_ff == 4'h0) begin
            done_ff <= 1'b1;
            state_ff <= C_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        default: state_ff <= C_IDLE;
      endcase
    end
  end

endmodule : bus_cycle_engine
`default_nettype wire

// ### flash_sector_protect_cmds.sv
// Purpose: Host sequencer for the flash sector guard command sets.
// Assumes: One user command at a time; byte_mode_i matches the strap.
// Notes: Each command enters its set, acts, then always exits.
`timescale 1ns/10ps
`default_nettype none
module flash_sector_protect_cmds #(
  parameter int ADDR_W = 24
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic cmd_valid_i,
  input wire fsp_pkg::op_type cmd_op_i,
  input wire logic [ADDR_W-fsp_pkg::SECTOR_LSB-1:0] cmd_sector_i,
  input wire logic [15:0] cmd_value_i,
  input wire logic byte_mode_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output logic [15:0] rsp_data_o,
  output logic rsp_guarded_o,
  output logic [ADDR_W-1:0] flash_addr_o,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe_o,
  input wire logic [15:0] flash_dq_i,
  output logic flash_ce_n_o,
  output logic flash_we_n_o,
  output logic flash_oe_n_o
);

  localparam int SECTOR_W = ADDR_W - fsp_pkg::SECTOR_LSB;

  // Refused at elaboration so no run-time check sits in the logic
  if (ADDR_W < 17 || ADDR_W > 32) begin : g_addr_w_check
    $error("ADDR_W must leave sector bits above bit 16");
  end

  typedef struct packed {
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [15:0] data;
    logic last;
  } step_type;

  typedef enum {T_IDLE, T_ISSUE, T_WAIT} top_state_type;

  function automatic logic [ADDR_W-1:0] cmd_addr(input logic [11:0] a);
    cmd_addr = {{(ADDR_W-12){1'b0}}, a};
  endfunction : cmd_addr

  function automatic step_type seq_step(
    input fsp_pkg::op_type op,
    input logic [fsp_pkg::STEP_W-1:0] step,
    input logic bmode,
    input logic [SECTOR_W-1:0] sector,
    input logic [15:0] value
  );
    step_type s;
    logic is_rd;
    logic [7:0] ent;
    logic [11:0] u2;
    logic [ADDR_W-1:0] sect_addr;
    s = '0;
    // Only the sector bits are set; lower bits stay zero
    sect_addr = {sector, {fsp_pkg::SECTOR_LSB{1'b0}}};
    is_rd = (op == fsp_pkg::OP_LOCK_READ) ||
            (op == fsp_pkg::OP_PERSIST_READ) ||
            (op == fsp_pkg::OP_FREEZE_READ) ||
            (op == fsp_pkg::OP_DYNAMIC_READ);
    case (op)
      fsp_pkg::OP_LOCK_PROG, fsp_pkg::OP_LOCK_READ: begin
        ent = fsp_pkg::ENT_LOCK;
        u2 = fsp_pkg::ADR_B_U2_SHORT;
      end
      fsp_pkg::OP_PERSIST_PROG, fsp_pkg::OP_PERSIST_ERASE,
      fsp_pkg::OP_PERSIST_READ: begin
        ent = fsp_pkg::ENT_PERSIST;
        u2 = fsp_pkg::ADR_B_U2_SHORT;
      end
      fsp_pkg::OP_FREEZE_SET, fsp_pkg::OP_FREEZE_READ: begin
        ent = fsp_pkg::ENT_FREEZE;
        u2 = fsp_pkg::ADR_B_U2_LONG;
      end
      default: begin
        ent = fsp_pkg::ENT_DYNAMIC;
        u2 = fsp_pkg::ADR_B_U2_LONG;
      end
    endcase
    if (!bmode) begin
      u2 = fsp_pkg::ADR_W_U2;
    end
    case (step)
      3'd0: begin
        s.addr = cmd_addr(bmode ? fsp_pkg::ADR_B_U1 : fsp_pkg::ADR_W_U1);
        s.data = {8'h00, fsp_pkg::CMD_UNLOCK1};
      end
      3'd1: begin
        s.addr = cmd_addr(u2);
        s.data = {8'h00, fsp_pkg::CMD_UNLOCK2};
      end
      3'd2: begin
        s.addr = cmd_addr(bmode ? fsp_pkg::ADR_B_U1 : fsp_pkg::ADR_W_U1);
        s.data = {8'h00, ent};
      end
      3'd3: begin
        if (is_rd) begin
          s.rd = 1'b1;
          if (op == fsp_pkg::OP_LOCK_READ) begin
            s.addr = cmd_addr(fsp_pkg::ADR_ZERO);
          end else if (op == fsp_pkg::OP_FREEZE_READ) begin
            s.addr = cmd_addr(fsp_pkg::ADR_ZERO);
          end else begin
            s.addr = sect_addr;
          end
        end else begin
          s.addr = cmd_addr(fsp_pkg::ADR_ZERO);
          s.data = (op == fsp_pkg::OP_PERSIST_ERASE) ?
            {8'h00, fsp_pkg::CMD_ERASE} : {8'h00, fsp_pkg::CMD_PROG};
        end
      end
      3'd4: begin
        if (is_rd) begin
          s.addr = cmd_addr(fsp_pkg::ADR_ZERO);
          s.data = {8'h00, fsp_pkg::CMD_EXIT1};
        end else begin
          case (op)
            fsp_pkg::OP_LOCK_PROG: begin
              s.addr = cmd_addr(fsp_pkg::ADR_ZERO);
              s.data = value;
            end
            fsp_pkg::OP_PERSIST_PROG: begin
              s.addr = sect_addr;
              s.data = {8'h00, fsp_pkg::GUARD_SET};
            end
            fsp_pkg::OP_PERSIST_ERASE: begin
              s.addr = cmd_addr(fsp_pkg::ADR_ZERO);
              s.data = {8'h00, fsp_pkg::CMD_ERASE_GO};
            end
            fsp_pkg::OP_FREEZE_SET: begin
              s.addr = cmd_addr(fsp_pkg::ADR_ZERO);
              s.data = {8'h00, fsp_pkg::GUARD_SET};
            end
            fsp_pkg::OP_DYNAMIC_SET: begin
              s.addr = sect_addr;
              s.data = {8'h00, fsp_pkg::GUARD_SET};
            end
            default: begin
              s.addr = sect_addr;
              s.data = {8'h00, fsp_pkg::GUARD_CLR};
            end
          endcase
        end
      end
      3'd5: begin
        s.addr = cmd_addr(fsp_pkg::ADR_ZERO);
        s.data = is_rd ? {8'h00, fsp_pkg::CMD_EXIT2} :
                         {8'h00, fsp_pkg::CMD_EXIT1};
        s.last = is_rd;
      end
      default: begin
        s.addr = cmd_addr(fsp_pkg::ADR_ZERO);
        s.data = {8'h00, fsp_pkg::CMD_EXIT2};
        s.last = 1'b1;
      end
    endcase
    seq_step = s;
  endfunction : seq_step

  cycle_if #(.ADDR_W(ADDR_W)) cyc ();

  top_state_type state_ff;
  fsp_pkg::op_type op_ff;
  logic [SECTOR_W-1:0] sector_ff;
  logic [15:0] value_ff;
  logic bmode_ff;
  logic [fsp_pkg::STEP_W-1:0] step_ff;
  logic req_ff;
  logic rd_ff;
  logic last_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [15:0] wdata_ff;
  step_type cur;

  assign cur = seq_step(op_ff, step_ff, bmode_ff, sector_ff, value_ff);
  assign cyc.req = req_ff;
  assign cyc.is_read = rd_ff;
  assign cyc.addr = addr_ff;
  assign cyc.wdata = wdata_ff;

  // Sequencing of the command steps
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= T_IDLE;
      op_ff <= fsp_pkg::OP_LOCK_READ;
      sector_ff <= '0;
      value_ff <= 16'h0000;
      bmode_ff <= 1'b0;
      step_ff <= '0;
      req_ff <= 1'b0;
      rd_ff <= 1'b0;
      last_ff <= 1'b0;
      addr_ff <= '0;
      wdata_ff <= 16'h0000;
      cmd_ready_o <= 1'b1;
    end else begin
      req_ff <= 1'b0;
      case (state_ff)
        T_IDLE: begin
          if (cmd_valid_i && cmd_ready_o) begin
            op_ff <= cmd_op_i;
            sector_ff <= cmd_sector_i;
            value_ff <= cmd_value_i;
            bmode_ff <= byte_mode_i;
            step_ff <= '0;
            cmd_ready_o <= 1'b0;
            state_ff <= T_ISSUE;
          end
        end
        T_ISSUE: begin
          req_ff <= 1'b1;
          rd_ff <= cur.rd;
          last_ff <= cur.last;
          addr_ff <= cur.addr;
          wdata_ff <= cur.data;
          state_ff <= T_WAIT;
        end
        T_WAIT: begin
          if (cyc.done) begin
            if (last_ff) begin
              cmd_ready_o <= 1'b1;
              state_ff <= T_IDLE;
            end else begin
              step_ff <= step_ff + 3'd1;
              state_ff <= T_ISSUE;
            end
          end
        end
        default: state_ff <= T_IDLE;
      endcase
    end
  end

  // Response capture; status reads use 00h as the guarded code, except the lock read, which takes bit 1 (LOCK_PERSIST_BIT)
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 16'h0000;
      rsp_guarded_o <= 1'b0;
    end else begin
      rsp_valid_o <= 1'b0;
      if (state_ff == T_WAIT && cyc.done) begin
        if (rd_ff) begin
          rsp_data_o <= cyc.rdata;
          if (op_ff == fsp_pkg::OP_LOCK_READ) begin
            rsp_guarded_o <= cyc.rdata[fsp_pkg::LOCK_PERSIST_BIT];
          end else begin
            rsp_guarded_o <= cyc.rdata[7:0] == fsp_pkg::STAT_GUARDED;
          end
        end
        if (last_ff) begin
          rsp_valid_o <= 1'b1;
        end
      end
    end
  end

  bus_cycle_engine #(.ADDR_W(ADDR_W)) u_engine (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .cyc(cyc.engine),
    .addr_o(flash_addr_o),
    .dq_o(flash_dq_o),
    .dq_oe_o(flash_dq_oe_o),
    .dq_i(flash_dq_i),
    .ce_n_o(flash_ce_n_o),
    .we_n_o(flash_we_n_o),
    .oe_n_o(flash_oe_n_o)
  );

endmodule : flash_sector_protect_cmds
`default_nettype wire

// ### fsp_chk_sva.sv
// Purpose: Pin-level checks of the sector guard command host.
// Assumes: Single clock domain; bound to the top module.
// Notes: Write index restarts at every accepted command.
`timescale 1ns/10ps
`default_nettype none
module fsp_chk #(
  parameter int ADDR_W = 24
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic cmd_valid_i,
  input wire logic byte_mode_i,
  input wire logic cmd_ready_o,
  input wire logic rsp_valid_o,
  input wire logic [ADDR_W-1:0] flash_addr_o,
  input wire logic [15:0] flash_dq_o,
  input wire logic flash_dq_oe_o,
  input wire logic flash_ce_n_o,
  input wire logic flash_we_n_o,
  input wire logic flash_oe_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic take;
  logic we_fall;
  logic bm_ff;
  logic we_ff;
  logic [3:0] idx_ff;
  logic [7:0] last_ff;
  logic [7:0] prev_ff;
  assign take = cmd_valid_i && cmd_ready_o;
  assign we_fall = we_ff && !flash_we_n_o;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      we_ff <= 1'b1;
      bm_ff <= 1'b0;
      idx_ff <= 4'h0;
    end else begin
      we_ff <= flash_we_n_o;
      if (take) begin
        bm_ff <= byte_mode_i;
        idx_ff <= 4'h0;
      end else if (we_fall) begin
        idx_ff <= idx_ff + 4'h1;
      end
    end
  end
  // Last two command bytes written, for the exit pair
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last_ff <= 8'h00;
      prev_ff <= 8'h00;
    end else if (we_fall) begin
      last_ff <= flash_dq_o[7:0];
      prev_ff <= last_ff;
    end
  end
  sequence s_we_pulse;
    !flash_we_n_o ##1 flash_we_n_o;
  endsequence
  a_we_in_ce: assert property (
    !flash_we_n_o |-> !flash_ce_n_o && flash_dq_oe_o && flash_oe_n_o)
    else $error("write strobe outside select");
  a_oe_in_ce: assert property (
    !flash_oe_n_o |-> !flash_ce_n_o && !flash_dq_oe_o)
    else $error("read strobe outside select");
  a_write_hold: assert property (
    !flash_we_n_o && !we_ff |-> $stable(flash_addr_o) && $stable(flash_dq_o))
    else $error("bus moved in write pulse");
  a_we_width: assert property (we_fall |=> s_we_pulse)
    else $error("write pulse width wrong");
  a_rsp_bound: assert property (take |-> ##[20:900] rsp_valid_o)
    else $error("command never answered");
  a_rsp_ready: assert property (
    rsp_valid_o |-> cmd_ready_o && !$past(cmd_ready_o))
    else $error("ready not tied to response");
  a_exit_pair: assert property (
    rsp_valid_o |-> last_ff == 8'h00 && prev_ff == 8'h90)
    else $error("exit pair missing");
  a_unlock_one: assert property (
    we_fall && idx_ff == 4'h0 |-> flash_dq_o[7:0] == 8'haa &&
    flash_addr_o[11:0] == (bm_ff ? 12'haaa : 12'h555))
    else $error("first unlock wrong");
  a_unlock_two: assert property (
    we_fall && idx_ff == 4'h1 |-> flash_dq_o[7:0] == 8'h55 &&
    (bm_ff ? flash_addr_o[11:0] inside {12'h055, 12'h555} :
    flash_addr_o[11:0] == 12'h2aa))
    else $error("second unlock wrong");
  a_unlock_three: assert property (
    we_fall && idx_ff == 4'h2 |->
    flash_dq_o[7:0] inside {8'h40, 8'hc0, 8'h50, 8'he0} &&
    flash_addr_o[11:0] == (bm_ff ? 12'haaa : 12'h555))
    else $error("set entry wrong");
endmodule : fsp_chk
bind flash_sector_protect_cmds fsp_chk #(.ADDR_W(ADDR_W)) fsp_chk_inst (
  .clk_i(clk_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid_i),
  .byte_mode_i(byte_mode_i), .cmd_ready_o(cmd_ready_o),
  .rsp_valid_o(rsp_valid_o), .flash_addr_o(flash_addr_o),
  .flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o),
  .flash_ce_n_o(flash_ce_n_o), .flash_we_n_o(flash_we_n_o),
  .flash_oe_n_o(flash_oe_n_o));
`default_nettype wire

// ### flash_guard_model.sv
// Purpose: Behavioural flash answering the sector guard command sets.
// Assumes: Host brackets its strobes inside chip select.
// Notes: Released data lines toggle so stale data never looks valid.
`timescale 1ns/10ps
`default_nettype none
module flash_guard_model #(
  parameter int ADDR_W = 24,
  parameter logic [15:0] LOCK_INIT = 16'hffff
) (
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [15:0] dq_i,
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic byte_mode_i,
  input wire logic [7:0] lat_ns_i,
  output logic [15:0] dq_o
);
  localparam int NS = 1 << (ADDR_W - 16);
  logic pers[NS];
  logic dyn[NS];
  logic frz;
  logic [15:0] lock_w;
  logic [7:0] mode;
  logic [7:0] pend;
  logic [11:0] a2;
  logic [ADDR_W-1:0] a_lat;
  int unl;
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    logic [11:0] lo;
    logic [11:0] u1;
    logic [ADDR_W-17:0] s;
    lo = a[11:0];
    u1 = byte_mode_i ? 12'haaa : 12'h555;
    s = a[ADDR_W-1:16];
    if (mode == 8'h00) begin
      case (unl)
        0: unl = (d[7:0] == 8'haa && lo == u1) ? 1 : 0;
        1: begin
          unl = (d[7:0] == 8'h55 && (byte_mode_i || lo == 12'h2aa)) ? 2 : 0;
          a2 = lo;
        end
        default: begin
          unl = 0;
          if (lo == u1 && d[7:0] inside {8'h40, 8'hc0, 8'h50, 8'he0} &&
              (!byte_mode_i ||
               a2 == ((d[4] | d[5]) ? 12'h555 : 12'h055))) begin
            mode = d[7:0];
          end
        end
      endcase
    end else if (pend == 8'h00) begin
      // Anything else inside a set is dropped
      if (d[7:0] inside {8'h90, 8'ha0} ||
          (d[7:0] == 8'h80 && mode == 8'hc0)) pend = d[7:0];
    end else begin
      if (pend == 8'h90 && d[7:0] == 8'h00) mode = 8'h00;
      if (pend == 8'h80 && d[7:0] == 8'h30 && lo == 12'h000 &&
          !frz) begin
        foreach (pers[i]) pers[i] = 1'b0;
      end
      if (pend == 8'ha0) begin
        case (mode)
          8'h40: lock_w = d;
          8'hc0: if (d[7:0] == 8'h00 && !frz) pers[s] = 1'b1;
          8'h50: if (d[7:0] == 8'h00) frz = 1'b1;
          default: if (d[7:0] <= 8'h01) dyn[s] = ~d[0];
        endcase
      end
      pend = 8'h00;
    end
  endtask : wr
  function automatic logic [15:0] rd(input logic [ADDR_W-1:0] a);
    case (mode)
      8'h40: rd = (a == '0) ? lock_w : 16'hffff;
      8'hc0: rd = {15'h0, ~pers[a[ADDR_W-1:16]]};
      8'h50: rd = {15'h0, ~frz};
      8'he0: rd = {15'h0, ~dyn[a[ADDR_W-1:16]]};
      default: rd = 16'hffff;
    endcase
  endfunction : rd
  initial begin
    foreach (pers[i]) pers[i] = 1'b0;
    foreach (dyn[i]) dyn[i] = 1'b0;
    frz = 1'b0;
    lock_w = LOCK_INIT;
    mode = 8'h00;
    pend = 8'h00;
    unl = 0;
    dq_o = 16'h5a5a;
  end
  always @(negedge we_n_i or negedge ce_n_i) begin
    if (!we_n_i && !ce_n_i) a_lat = addr_i;
  end
  always @(posedge we_n_i or posedge ce_n_i) begin
    if (we_n_i ^ ce_n_i) wr(a_lat, dq_i);
  end
  always @(negedge oe_n_i) begin
    dq_o = ~dq_o;
    #(lat_ns_i);
    if (!oe_n_i && !ce_n_i) dq_o = rd(addr_i);
  end
  always @(posedge oe_n_i or posedge ce_n_i) dq_o = ~dq_o;
endmodule : flash_guard_model
`default_nettype wire

// ### flash_sector_protect_cmds_tb_top.sv
// Purpose: Self-checking bench for the sector guard command host.
// Assumes: Flash model holds the reference state in parallel with ours.
// Notes: Write commands must leave the last read result untouched.
`timescale 1ns/10ps
`default_nettype none
module flash_sector_protect_cmds_tb_top;
  typedef struct packed {
    logic [15:0] d;
    logic g;
  } exp_type;
  logic clk_i, nrst_i, cmd_valid_i, byte_mode_i;
  fsp_pkg::op_type cmd_op_i;
  logic [7:0] cmd_sector_i, lat_ns;
  logic [15:0] cmd_value_i, rsp_data_o, flash_dq_o, mdl_dq, dq_bus;
  logic cmd_ready_o, rsp_valid_o, rsp_guarded_o;
  logic [23:0] flash_addr_o;
  logic flash_dq_oe_o, flash_ce_n_o, flash_we_n_o, flash_oe_n_o;
  logic pers_r[256];
  logic dyn_r[256];
  logic frz_r;
  logic [15:0] lock_r;
  exp_type last_e, mon_e;
  exp_type exp_q[$];
  int error_cnt, num_checks;
  assign dq_bus = flash_dq_oe_o ? flash_dq_o : mdl_dq;
  flash_sector_protect_cmds #(.ADDR_W(24)) flash_sector_protect_cmds_inst (
    .clk_i(clk_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_op_i(cmd_op_i), .cmd_sector_i(cmd_sector_i),
    .cmd_value_i(cmd_value_i), .byte_mode_i(byte_mode_i),
    .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .rsp_guarded_o(rsp_guarded_o),
    .flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o),
    .flash_dq_oe_o(flash_dq_oe_o), .flash_dq_i(dq_bus),
    .flash_ce_n_o(flash_ce_n_o), .flash_we_n_o(flash_we_n_o),
    .flash_oe_n_o(flash_oe_n_o));
  flash_guard_model #(.ADDR_W(24)) flash_guard_model_inst (
    .addr_i(flash_addr_o), .dq_i(dq_bus), .ce_n_i(flash_ce_n_o),
    .we_n_i(flash_we_n_o), .oe_n_i(flash_oe_n_o),
    .byte_mode_i(byte_mode_i), .lat_ns_i(lat_ns), .dq_o(mdl_dq));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk16(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk16
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  // Waits for idle first so byte mode never changes under a running command
  task automatic do_cmd(input fsp_pkg::op_type op, input logic [7:0] s,
                        input logic [15:0] v, input logic bm);
    int n;
    exp_type e;
    n = 0;
    @(negedge clk_i);
    while (cmd_ready_o !== 1'b1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 3000) begin
      error_cnt++;
      $display("ERROR cmd_ready expected 1 seen %b", cmd_ready_o);
    end
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_op_i <= op;
    cmd_sector_i <= s;
    cmd_value_i <= v;
    byte_mode_i <= bm;
    lat_ns <= 8'($urandom_range(0, 80));
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    e = last_e;
    case (op)
      fsp_pkg::OP_LOCK_PROG: lock_r = v;
      fsp_pkg::OP_LOCK_READ: e = '{lock_r, lock_r[1]};
      fsp_pkg::OP_PERSIST_PROG: if (!frz_r) pers_r[s] = 1'b1;
      fsp_pkg::OP_PERSIST_ERASE:
        if (!frz_r) foreach (pers_r[i]) pers_r[i] = 1'b0;
      fsp_pkg::OP_PERSIST_READ: e = '{{15'h0, !pers_r[s]}, pers_r[s]};
      fsp_pkg::OP_FREEZE_SET: frz_r = 1'b1;
      fsp_pkg::OP_FREEZE_READ: e = '{{15'h0, !frz_r}, frz_r};
      fsp_pkg::OP_DYNAMIC_SET: dyn_r[s] = 1'b1;
      fsp_pkg::OP_DYNAMIC_CLR: dyn_r[s] = 1'b0;
      default: e = '{{15'h0, !dyn_r[s]}, dyn_r[s]};
    endcase
    last_e = e;
    exp_q.push_back(e);
  endtask : do_cmd
  always @(negedge clk_i) begin
    if (rsp_valid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("ERROR rsp_valid expected none seen 1");
      end else begin
        mon_e = exp_q.pop_front();
        chk16("rsp_data", mon_e.d, rsp_data_o);
        chk16("rsp_guarded", {15'h0, mon_e.g}, {15'h0, rsp_guarded_o});
      end
    end
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    logic [7:0] s;
    void'($urandom(95752));
    error_cnt = 0;
    num_checks = 0;
    nrst_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_op_i = fsp_pkg::OP_LOCK_READ;
    cmd_sector_i = 8'h00;
    cmd_value_i = 16'h0000;
    byte_mode_i = 1'b0;
    lat_ns = 8'h00;
    frz_r = 1'b0;
    lock_r = 16'hffff;
    last_e = '0;
    foreach (pers_r[i]) pers_r[i] = 1'b0;
    foreach (dyn_r[i]) dyn_r[i] = 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    s = 8'($urandom);
    do_cmd(fsp_pkg::OP_FREEZE_READ, 8'h00, 16'h0, 1'b0);
    do_cmd(fsp_pkg::OP_DYNAMIC_READ, s, 16'h0, 1'b0);
    for (int b = 0; b < 2; b++) begin
      do_cmd(fsp_pkg::OP_LOCK_PROG, s, 16'($urandom), b[0]);
      do_cmd(fsp_pkg::OP_LOCK_READ, s, 16'h0, b[0]);
      do_cmd(fsp_pkg::OP_PERSIST_PROG, s, 16'h0, b[0]);
      do_cmd(fsp_pkg::OP_PERSIST_READ, s, 16'h0, b[0]);
      do_cmd(fsp_pkg::OP_PERSIST_READ, s ^ 8'h01, 16'h0, b[0]);
      do_cmd(fsp_pkg::OP_DYNAMIC_SET, s, 16'h0, b[0]);
      do_cmd(fsp_pkg::OP_DYNAMIC_READ, s, 16'h0, b[0]);
      do_cmd(fsp_pkg::OP_DYNAMIC_CLR, s, 16'h0, b[0]);
      do_cmd(fsp_pkg::OP_DYNAMIC_READ, s, 16'h0, b[0]);
      do_cmd(fsp_pkg::OP_PERSIST_ERASE, s, 16'h0, b[0]);
      do_cmd(fsp_pkg::OP_PERSIST_READ, s, 16'h0, b[0]);
    end
    do_cmd(fsp_pkg::OP_PERSIST_PROG, s, 16'h0, 1'b1);
    do_cmd(fsp_pkg::OP_FREEZE_SET, s, 16'h0, 1'b1);
    do_cmd(fsp_pkg::OP_FREEZE_READ, 8'($urandom), 16'h0, 1'b0);
    do_cmd(fsp_pkg::OP_PERSIST_ERASE, s, 16'h0, 1'b0);
    do_cmd(fsp_pkg::OP_PERSIST_READ, s, 16'h0, 1'b0);
    repeat (24) begin
      do_cmd(fsp_pkg::op_type'($urandom_range(0, 9)), 8'($urandom),
             16'($urandom), 1'($urandom));
    end
    for (int n = 0; n < 3000 && exp_q.size() > 0; n++) @(negedge clk_i);
    // A response that never came must not slip through as a pass
    if (exp_q.size() != 0) begin
      error_cnt++;
      $display("ERROR rsp_valid expected %0d more seen none", exp_q.size());
    end
    report_and_stop();
  end
endmodule : flash_sector_protect_cmds_tb_top
`default_nettype wire
